// ===== bench/flash_cmd_host_tb_top.sv
// self-checking bench for the flash command host controller
`timescale 1ns/10ps
module flash_cmd_host_tb_top;
	localparam int          GAP   = 200;
	localparam int          LIMIT = 40000;
	localparam logic [21:0] ES    = 22'h318000;
	logic                 clk = 0, sys_rst = 1, cmd_valid = 0, rf;
	flash_host_pkg::cmd_s cmd = '0;
	logic                 cmd_ready, cmd_refused, rsp_valid, erase_suspended, bypass_active;
	logic                 dq_oe, ce_n, we_n, oe_n;
	logic [15:0]          rsp_data, dq_out, dq_in, dev_dq, s, d;
	logic [21:0]          flash_addr, a;
	logic [15:0]          rq [$];
	logic [15:0]          bd [4];
	int                   num_errors = 0, checks_done = 0, cyc = 0, n, nw;

	assign dq_in = dq_oe ? dq_out : dev_dq;
	flash_cmd_host #(.RESUME_GAP(GAP)) uut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .erase_suspended(erase_suspended), .bypass_active(bypass_active),
		.flash_addr(flash_addr), .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n));
	flash_dev_model dev (.addr(flash_addr), .dq_in(dq_in), .dq_out(dev_dq), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n));

	initial forever #5 clk = ~clk;

	// ==========================================
	// checking and bus tasks
	function automatic logic [15:0] exp_rd(logic [21:0] x);
		return x[15:0] ^ 16'h5a5a;
	endfunction
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic op(flash_host_pkg::op_e o, logic [21:0] x, logic [15:0] v);
		@(negedge clk);
		cmd_valid = 1;
		cmd = '{o, x, v};
		for (n = 0; cmd_ready !== 1'b1 && n < 100; n++)
			@(negedge clk);
		@(negedge clk);
		cmd_valid = 0;
		rf = cmd_refused;
		@(negedge clk);
		rf = rf | cmd_refused;
		for (n = 2; cmd_ready !== 1'b1 && n < 5000; n++)
			@(negedge clk);
		repeat (2) @(negedge clk);
	endtask
	task automatic rd(flash_host_pkg::op_e o, logic [21:0] x);
		op(o, x, '0);
		s = rq.size() > 0 ? rq.pop_front() : 16'hxxxx;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (rsp_valid === 1'b1)
			rq.push_back(rsp_data);
		if (cyc == LIMIT)
		begin
			num_errors++;
			end_sim();
		end
	end

	// ==========================================
	// scenarios
	initial
	begin
		void'($urandom(32'h0ea0bbd5));
		repeat (4) @(negedge clk);
		sys_rst = 0;
		@(negedge clk);
		chk({cmd_ready, ce_n, we_n, oe_n, dq_oe, erase_suspended, bypass_active}, 16'h0078);
		op(flash_host_pkg::OP_SUSPEND, '0, '0);
		chk(rf, 1);
		op(flash_host_pkg::OP_RESUME, '0, '0);
		chk(rf, 1);
		for (int k = 0; k < 4; k++)
		begin
			a = 22'($urandom) & 22'h0fffff;
			d = 16'($urandom);
			op(flash_host_pkg::OP_PROGRAM, a, d);
			rd(flash_host_pkg::OP_READ, a);
			chk(s, d);
			rd(flash_host_pkg::OP_READ, a | 22'h200000);
			chk(s, exp_rd(a | 22'h200000));
		end
		op(flash_host_pkg::OP_SECT_ERASE, ES | 22'h000123, '0);
		op(flash_host_pkg::OP_SUSPEND, '0, '0);
		chk({rf, erase_suspended, n >= 2000}, 3'b011);
		rd(flash_host_pkg::OP_READ, ES);
		d = s;
		rd(flash_host_pkg::OP_READ, ES | 22'h007fff);
		chk({s[7], d[7], s[2] ^ d[2]}, 3'b111);
		d = 16'($urandom);
		op(flash_host_pkg::OP_PROGRAM, 22'h010040, d);
		rd(flash_host_pkg::OP_READ, 22'h010040);
		chk(erase_suspended, 1);
		chk(s, d);
		rd(flash_host_pkg::OP_PROT_VERIFY, 22'h02ffff);
		chk(s, 16'h0001);
		rd(flash_host_pkg::OP_PROT_VERIFY, 22'h030000);
		chk(s, 16'h0000);
		rd(flash_host_pkg::OP_LOCK_IND, '0);
		chk(s, 16'h0018);
		rd(flash_host_pkg::OP_READ, ES);
		chk({erase_suspended, s[7]}, 2'b11);
		op(flash_host_pkg::OP_RESUME, '0, '0);
		chk({rf, erase_suspended, dev.susp}, 3'b000);
		op(flash_host_pkg::OP_RESUME, '0, '0);
		chk(rf, 1);
		op(flash_host_pkg::OP_SUSPEND, '0, '0);
		chk(rf, 1);
		repeat (GAP) @(negedge clk);
		op(flash_host_pkg::OP_SUSPEND, '0, '0);
		chk({rf, erase_suspended}, 2'b01);
		op(flash_host_pkg::OP_RESUME, '0, '0);
		op(flash_host_pkg::OP_RESET, '0, '0);
		chk(rf, 0);
		op(flash_host_pkg::OP_DEV_ID, '0, '0);
		for (int k = 0; k < 3; k++)
			chk(rq.size() > 0 ? rq.pop_front() : 16'hxxxx, 16'h0a11 + 16'(k) * 16'h1111);
		op(flash_host_pkg::OP_BYP_ENTER, '0, '0);
		op(flash_host_pkg::OP_SECT_ERASE, ES, '0);
		chk({bypass_active, rf}, 2'b11);
		for (int k = 0; k < 3; k++)
		begin
			a = 22'($urandom) & 22'h0fffff;
			d = 16'($urandom);
			op(flash_host_pkg::OP_BYP_PROG, a, d);
			rd(flash_host_pkg::OP_READ, a);
			chk(s, d);
		end
		op(flash_host_pkg::OP_BYP_EXIT, '0, '0);
		chk({bypass_active, dev.byp}, 2'b00);
		op(flash_host_pkg::OP_BYP_PROG, 22'h000100, 16'h0001);
		chk(rf, 1);
		nw = $urandom_range(4, 1);
		a = 22'h1f0000 | (22'($urandom) & 22'h00fff0);
		op(flash_host_pkg::OP_BUF_LOAD, a, 16'(nw));
		for (int k = 0; k < nw; k++)
		begin
			bd[k] = 16'($urandom);
			op(flash_host_pkg::OP_BUF_WORD, a + 22'(k), bd[k]);
		end
		op(flash_host_pkg::OP_BUF_COMMIT, a, '0);
		for (int k = 0; k < nw; k++)
		begin
			rd(flash_host_pkg::OP_READ, a + 22'(k));
			chk(s, bd[k]);
		end
		op(flash_host_pkg::OP_BUF_LOAD, a | 22'h8, 16'h0002);
		op(flash_host_pkg::OP_BUF_WORD, a | 22'h8, 16'h1234);
		op(flash_host_pkg::OP_BUF_ABORT, '0, '0);
		rd(flash_host_pkg::OP_READ, a | 22'h8);
		chk(dev.abt, 0);
		chk(s, exp_rd(a | 22'h8));
		end_sim();
	end
endmodule

// ===== bench/flash_dev_model.sv
// behavioural flash device answering the host controller bus cycles
`timescale 1ns/10ps
module flash_dev_model #(
	parameter logic [15:0] ID1  = 16'h0a11, // arbitrary
	parameter logic [15:0] ID2  = 16'h1b22, // arbitrary
	parameter logic [15:0] ID3  = 16'h2c33, // arbitrary
	parameter logic [6:0]  PROT = 7'h05
) (
	// flash pins
	input  wire logic [21:0] addr,
	input  wire logic [15:0] dq_in,
	output logic      [15:0] dq_out,
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n
);
	logic [15:0] mem [int];
	logic [15:0] bq  [int];
	logic [21:0] a_lat, pa0 = '0, pa1 = '0;
	logic [15:0] pd0 = '0, pd1 = '0, rd_last = '0;
	logic [6:0]  es;
	logic        act = 0, asel = 0, byp = 0, ers = 0, susp = 0, prog = 0, s80 = 0, abt = 0;
	logic        tog = 0;
	int          bst = 0, bcnt;

	// released bus shows the inverse of the last word
	assign dq_out = (!oe_n && !ce_n) ? rd_last : ~rd_last;

	// ==========================================
	// read answer
	function automatic logic [15:0] rdv(logic [21:0] a);
		if (asel)
			case (a[7:0])
				8'h01: return ID1;
				8'h0e: return ID2;
				8'h0f: return ID3;
				8'h02: return {15'h0, a[21:15] == PROT};
				8'h03: return 16'h0018;
				default: return 16'h0000;
			endcase
		if (susp && a[21:15] == es)
		begin
			tog = !tog;
			return {8'h00, 5'h10, tog, 2'h0};
		end
		return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5a5a;
	endfunction

	// ==========================================
	// write decode, one call per finished strobe
	task automatic wr(logic [21:0] a, logic [15:0] d);
		logic u;
		u = pa1[11:0] == 12'h555 && pd1[7:0] == 8'haa;
		u = u && pa0[11:0] == 12'h2aa && pd0[7:0] == 8'h55;
		if (u && d[7:0] == 8'hf0)
			{bst, abt, asel} = '0;
		else if (prog)
		begin
			mem[a] = d;
			prog = 0;
		end
		else if (bst == 1)
			{bcnt, bst} = {16'h0, d, 32'd2};
		else if (bst == 2)
		begin
			bq[a] = d;
			bst = bq.num() == bcnt + 1 ? 3 : 2;
		end
		else if (bst == 3)
		begin
			if (d[7:0] == 8'h29)
				foreach (bq[k]) mem[k] = bq[k];
			abt = d[7:0] != 8'h29;
			bq.delete();
			bst = 0;
		end
		else if (byp)
		begin
			prog = d == 16'h00a0;
			byp = !(pd0 == 16'h0090 && d == 16'h0000);
		end
		else if (d[7:0] == 8'hf0)
			{asel, ers} = {1'b0, ers && susp};
		else if (d[7:0] == 8'hb0)
			susp = ers;
		else if (u && s80 && d[7:0] == 8'h30)
			{ers, es, s80} = {1'b1, a[21:15], 1'b0};
		else if (d[7:0] == 8'h30)
			susp = 0;
		else if (u)
		begin
			s80 = d[7:0] == 8'h80;
			asel = asel || d[7:0] == 8'h90;
			prog = d[7:0] == 8'ha0;
			byp = d[7:0] == 8'h20;
			bst = d[7:0] == 8'h25 ? 1 : 0;
		end
		{pa1, pd1, pa0, pd0} = {pa0, pd0, a, d};
	endtask

	always @(negedge we_n or negedge ce_n)
		if (!we_n && !ce_n)
		begin
			a_lat = addr;
			act = 1;
		end
	always @(posedge we_n or posedge ce_n)
		if (act)
		begin
			act = 0;
			wr(a_lat, dq_in);
		end
	always @(negedge oe_n or negedge ce_n)
		if (!oe_n && !ce_n)
			rd_last = rdv(addr);
endmodule

// ===== design/flash_cmd_host.sv
// host controller issuing flash command sequences over the parallel bus
// Function
// - suspend only issued while a sector erase is running, any address
// - resume continues suspended erase; extra resumes ignored; new suspend allowed
// - no rapid suspend/resume pairs; a minimum gap is enforced
// - protect verify: unlock, autoselect, read sector offset 02
// - bypass entry 555/aa 2aa/55 555/20; bypass program a0 then data
// - bypass exit: 90 then 00 at any address
// - buffer load: unlock, 25 at sector, count at sector, data words
// - write 29 at sector to program the buffer
// - abort reset: two unlock cycles then f0 at 555
// - resume is one write of 30 at any address
// - single f0 write leaves autoselect or clears failure
// - word count written equals locations loaded minus one
// - device identification read in three cycles at distinct offsets
`timescale 1ns/10ps
module flash_cmd_host #(
	parameter int RESUME_GAP = flash_host_pkg::RGAP_CYC
) (
	// clock and reset
	input  wire logic                              clk,
	input  wire logic                              sys_rst,
	// user command side
	input  wire logic                              cmd_valid,
	input  wire flash_host_pkg::cmd_s              cmd,
	output logic                                   cmd_ready,
	output logic                                   cmd_refused,
	output logic                                   rsp_valid,
	output logic [flash_host_pkg::DATA_W-1:0]      rsp_data,
	output logic                                   erase_suspended,
	output logic                                   bypass_active,
	// flash pins
	output logic [flash_host_pkg::ADDR_W-1:0]      flash_addr,
	input  wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
	output logic [flash_host_pkg::DATA_W-1:0]      flash_dq_out,
	output logic                                   flash_dq_oe,
	output logic                                   flash_ce_n,
	output logic                                   flash_we_n,
	output logic                                   flash_oe_n
);

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_WAIT} state_e;

	localparam logic [flash_host_pkg::CNT_W-1:0] WE_LAST   = 14'(flash_host_pkg::WE_CYC - 1);
	localparam logic [flash_host_pkg::CNT_W-1:0] RD_LAST   = 14'(flash_host_pkg::RD_CYC - 1);
	localparam logic [flash_host_pkg::CNT_W-1:0] HOLD_LAST = 14'(flash_host_pkg::HOLD_CYC - 1);
	localparam logic [flash_host_pkg::CNT_W-1:0] SUSP_LAST = 14'(flash_host_pkg::SUSP_CYC - 1);
	localparam logic [flash_host_pkg::CNT_W-1:0] GAP_LOAD  = 14'(RESUME_GAP);
	localparam logic [flash_host_pkg::CNT_W-1:0] CNT_ZERO  = 14'h0000;
	localparam logic [2:0]                       IDX_ZERO  = 3'h0;
	localparam logic [2:0]                       IDX_ONE   = 3'h1;

	// ==========================================
	// sequence table
	function automatic flash_host_pkg::step_s mk(input logic rd, input logic last,
		input flash_host_pkg::asel_e asel, input logic [21:0] aval,
		input flash_host_pkg::dsel_e dsel, input logic [15:0] dval);
		mk = '{rd, last, asel, aval, dsel, dval};
	endfunction

	function automatic flash_host_pkg::step_s step_of(input flash_host_pkg::op_e op,
		input logic [2:0] idx);
		import flash_host_pkg::*;
		step_s u1;
		step_s u2;
		u1 = mk(1'b0, 1'b0, AS_CONST, A_UNLOCK1, DS_CONST, D_UNLOCK1);
		u2 = mk(1'b0, 1'b0, AS_CONST, A_UNLOCK2, DS_CONST, D_UNLOCK2);
		step_of = mk(1'b0, 1'b1, AS_CONST, A_ANY, DS_CONST, D_RESET);
		if (idx == 3'h0 && op inside {OP_SECT_ERASE, OP_PROGRAM, OP_BYP_ENTER, OP_BUF_LOAD,
			OP_BUF_ABORT, OP_DEV_ID, OP_PROT_VERIFY, OP_LOCK_IND})
			step_of = u1;
		else if (idx == 3'h1 && op inside {OP_SECT_ERASE, OP_PROGRAM, OP_BYP_ENTER,
			OP_BUF_LOAD, OP_BUF_ABORT, OP_DEV_ID, OP_PROT_VERIFY, OP_LOCK_IND})
			step_of = u2;
		else
			case (op)
				OP_READ:        step_of = mk(1'b1, 1'b1, AS_USER, A_ANY, DS_CONST, D_ZERO);
				OP_SUSPEND:     step_of = mk(1'b0, 1'b1, AS_CONST, A_ANY, DS_CONST, D_SUSPEND);
				OP_RESUME:      step_of = mk(1'b0, 1'b1, AS_CONST, A_ANY, DS_CONST, D_RESUME);
				OP_SECT_ERASE:
					case (idx)
						3'h2:    step_of = mk(1'b0, 1'b0, AS_CONST, A_UNLOCK1, DS_CONST, D_ERASE);
						3'h3:    step_of = u1;
						3'h4:    step_of = u2;
						default: step_of = mk(1'b0, 1'b1, AS_SECT, A_ANY, DS_CONST, D_SECT_ERS);
					endcase
				OP_PROGRAM:
					if (idx == 3'h2)
						step_of = mk(1'b0, 1'b0, AS_CONST, A_UNLOCK1, DS_CONST, D_PROGRAM);
					else
						step_of = mk(1'b0, 1'b1, AS_USER, A_ANY, DS_USER, D_ZERO);
				OP_BYP_ENTER:   step_of = mk(1'b0, 1'b1, AS_CONST, A_UNLOCK1, DS_CONST, D_BYPASS);
				OP_BYP_PROG:
					if (idx == 3'h0)
						step_of = mk(1'b0, 1'b0, AS_CONST, A_ANY, DS_CONST, D_PROGRAM);
					else
						step_of = mk(1'b0, 1'b1, AS_USER, A_ANY, DS_USER, D_ZERO);
				OP_BYP_EXIT:
					if (idx == 3'h0)
						step_of = mk(1'b0, 1'b0, AS_CONST, A_ANY, DS_CONST, D_AUTOSEL);
					else
						step_of = mk(1'b0, 1'b1, AS_CONST, A_ANY, DS_CONST, D_ZERO);
				OP_BUF_LOAD:
					if (idx == 3'h2)
						step_of = mk(1'b0, 1'b0, AS_SECT, A_ANY, DS_CONST, D_BUF_LOAD);
					else
						step_of = mk(1'b0, 1'b1, AS_SECT, A_ANY, DS_WC, D_ZERO);
				OP_BUF_WORD:    step_of = mk(1'b0, 1'b1, AS_USER, A_ANY, DS_USER, D_ZERO);
				OP_BUF_COMMIT:  step_of = mk(1'b0, 1'b1, AS_SECT, A_ANY, DS_CONST, D_BUF_GO);
				OP_BUF_ABORT:   step_of = mk(1'b0, 1'b1, AS_CONST, A_UNLOCK1, DS_CONST, D_RESET);
				OP_DEV_ID, OP_PROT_VERIFY, OP_LOCK_IND:
					case (idx)
						3'h2:    step_of = mk(1'b0, 1'b0, AS_CONST, A_UNLOCK1, DS_CONST, D_AUTOSEL);
						3'h3:    step_of = (op == OP_DEV_ID)
							? mk(1'b1, 1'b0, AS_CONST, OFF_ID1, DS_CONST, D_ZERO)
							: (op == OP_PROT_VERIFY)
							? mk(1'b1, 1'b0, AS_SECT, OFF_PROT, DS_CONST, D_ZERO)
							: mk(1'b1, 1'b0, AS_CONST, OFF_LOCK, DS_CONST, D_ZERO);
						3'h4:    step_of = (op == OP_DEV_ID)
							? mk(1'b1, 1'b0, AS_CONST, OFF_ID2, DS_CONST, D_ZERO)
							: mk(1'b0, 1'b1, AS_CONST, A_ANY, DS_CONST, D_RESET);
						3'h5:    step_of = mk(1'b1, 1'b0, AS_CONST, OFF_ID3, DS_CONST, D_ZERO);
						default: step_of = mk(1'b0, 1'b1, AS_CONST, A_ANY, DS_CONST, D_RESET);
					endcase
				default:        step_of = mk(1'b0, 1'b1, AS_CONST, A_ANY, DS_CONST, D_RESET);
			endcase
	endfunction

	// ==========================================
	// state
	state_e                                  state_reg, state_next;
	flash_host_pkg::cmd_s                    cmd_reg, cmd_next;
	logic [2:0]                              idx_reg, idx_next;
	logic [flash_host_pkg::CNT_W-1:0]        cnt_reg, cnt_next, gap_reg, gap_next;
	logic                                    active_reg, active_next;
	logic                                    susp_reg, susp_next, byp_reg, byp_next;
	logic                                    refused_reg, rsp_valid_reg, ready_reg;
	logic [flash_host_pkg::DATA_W-1:0]       rsp_data_reg;
	logic [flash_host_pkg::ADDR_W-1:0]       addr_reg;
	logic [flash_host_pkg::DATA_W-1:0]       dq_out_reg;
	logic                                    dq_oe_reg, ce_n_reg, we_n_reg, oe_n_reg;

	// ==========================================
	// decode
	wire flash_host_pkg::step_s cur  = step_of(cmd_reg.op, idx_reg);
	wire flash_host_pkg::step_s nxt  = step_of(cmd_next.op, idx_next);
	wire logic take      = cmd_valid && ready_reg;
	wire logic op_legal  =
		(cmd.op == flash_host_pkg::OP_SUSPEND)    ? active_reg && gap_reg == CNT_ZERO :
		(cmd.op == flash_host_pkg::OP_RESUME)     ? susp_reg :
		(cmd.op == flash_host_pkg::OP_BYP_PROG)   ? byp_reg :
		(cmd.op == flash_host_pkg::OP_BYP_EXIT)   ? byp_reg :
		(cmd.op == flash_host_pkg::OP_READ)       ? 1'b1 :
		byp_reg ? 1'b0 :
		(cmd.op == flash_host_pkg::OP_RESET)      ? 1'b1 :
		(cmd.op == flash_host_pkg::OP_SECT_ERASE) ? !active_reg && !susp_reg :
		(cmd.op == flash_host_pkg::OP_BYP_ENTER)  ? !active_reg && !susp_reg :
		!active_reg;
	wire logic go        = take && op_legal;
	wire logic [flash_host_pkg::CNT_W-1:0] strobe_last = cur.rd ? RD_LAST : WE_LAST;
	wire logic strobe_end = state_reg == ST_STROBE && cnt_reg == strobe_last;
	wire logic hold_end  = state_reg == ST_HOLD && cnt_reg == HOLD_LAST;
	wire logic wait_end  = state_reg == ST_WAIT && cnt_reg == SUSP_LAST;
	wire logic op_done   = hold_end && cur.last;
	wire logic [21:0] sect_of = cmd_next.addr & flash_host_pkg::SECT_MASK;
	wire logic [21:0] addr_n  = (nxt.asel == flash_host_pkg::AS_USER) ? cmd_next.addr :
		(nxt.asel == flash_host_pkg::AS_SECT) ? (sect_of | nxt.aval) : nxt.aval;
	wire logic [15:0] wc_val  = 16'(cmd_next.data - flash_host_pkg::D_ONE);
	wire logic [15:0] data_n  = (nxt.dsel == flash_host_pkg::DS_USER) ? cmd_next.data :
		(nxt.dsel == flash_host_pkg::DS_WC) ? wc_val : nxt.dval;
	wire logic enter_setup = state_next == ST_SETUP;
	wire logic nxt_rd_sel = (state_next == ST_SETUP) ? nxt.rd : cur.rd;

	// ==========================================
	// sequencer
	always_comb
	begin
		state_next = state_reg;
		cmd_next   = cmd_reg;
		idx_next   = idx_reg;
		cnt_next   = cnt_reg + 14'h0001;
		case (state_reg)
			ST_IDLE:
			begin
				cnt_next = CNT_ZERO;
				if (go)
				begin
					cmd_next   = cmd;
					idx_next   = IDX_ZERO;
					state_next = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				cnt_next   = CNT_ZERO;
				state_next = ST_STROBE;
			end
			ST_STROBE:
				if (strobe_end)
				begin
					cnt_next   = CNT_ZERO;
					state_next = ST_HOLD;
				end
			ST_HOLD:
				if (hold_end)
				begin
					cnt_next = CNT_ZERO;
					if (!cur.last)
					begin
						idx_next   = idx_reg + IDX_ONE;
						state_next = ST_SETUP;
					end
					else if (cmd_reg.op == flash_host_pkg::OP_SUSPEND)
						state_next = ST_WAIT;
					else
						state_next = ST_IDLE;
				end
			ST_WAIT:
				if (wait_end)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	// mode flags follow completed sequences
	always_comb
	begin
		active_next = active_reg;
		susp_next   = susp_reg;
		byp_next    = byp_reg;
		gap_next    = (gap_reg == CNT_ZERO) ? CNT_ZERO : gap_reg - 14'h0001;
		if (op_done)
			case (cmd_reg.op)
				flash_host_pkg::OP_SECT_ERASE: active_next = 1'b1;
				flash_host_pkg::OP_SUSPEND:    active_next = 1'b0;
				flash_host_pkg::OP_RESUME:
				begin
					active_next = 1'b1;
					susp_next   = 1'b0;
					gap_next    = GAP_LOAD;
				end
				flash_host_pkg::OP_RESET:      active_next = 1'b0;
				flash_host_pkg::OP_BYP_ENTER:  byp_next = 1'b1;
				flash_host_pkg::OP_BYP_EXIT:   byp_next = 1'b0;
				default:                       byp_next = byp_reg;
			endcase
		if (wait_end)
			susp_next = 1'b1;
	end

	always_ff @(posedge clk)
		if (sys_rst)
		begin
			state_reg <= ST_IDLE;
			cmd_reg   <= '0;
			idx_reg   <= IDX_ZERO;
			cnt_reg   <= CNT_ZERO;
			gap_reg   <= CNT_ZERO;
		end
		else
		begin
			state_reg <= state_next;
			cmd_reg   <= cmd_next;
			idx_reg   <= idx_next;
			cnt_reg   <= cnt_next;
			gap_reg   <= gap_next;
		end

	always_ff @(posedge clk)
		if (sys_rst)
		begin
			active_reg    <= 1'b0;
			susp_reg      <= 1'b0;
			byp_reg       <= 1'b0;
			refused_reg   <= 1'b0;
			ready_reg     <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= flash_host_pkg::D_ZERO;
		end
		else
		begin
			active_reg    <= active_next;
			susp_reg      <= susp_next;
			byp_reg       <= byp_next;
			refused_reg   <= take && !op_legal;
			ready_reg     <= state_next == ST_IDLE;
			rsp_valid_reg <= strobe_end && cur.rd;
			if (strobe_end && cur.rd)
				rsp_data_reg <= flash_dq_in;
		end

	// ==========================================
	// pin drivers, address latched before strobe falls
	always_ff @(posedge clk)
		if (sys_rst)
		begin
			addr_reg   <= flash_host_pkg::A_ANY;
			dq_out_reg <= flash_host_pkg::D_ZERO;
			dq_oe_reg  <= 1'b0;
			ce_n_reg   <= 1'b1;
			we_n_reg   <= 1'b1;
			oe_n_reg   <= 1'b1;
		end
		else
		begin
			if (enter_setup)
			begin
				addr_reg   <= addr_n;
				dq_out_reg <= data_n;
			end
			dq_oe_reg <= (state_next inside {ST_SETUP, ST_STROBE, ST_HOLD}) && !nxt_rd_sel;
			ce_n_reg  <= state_next != ST_STROBE;
			we_n_reg  <= !(state_next == ST_STROBE && !nxt_rd_sel);
			oe_n_reg  <= !(state_next == ST_STROBE && nxt_rd_sel);
		end

	assign cmd_ready       = ready_reg;
	assign cmd_refused     = refused_reg;
	assign rsp_valid       = rsp_valid_reg;
	assign rsp_data        = rsp_data_reg;
	assign erase_suspended = susp_reg;
	assign bypass_active   = byp_reg;
	assign flash_addr      = addr_reg;
	assign flash_dq_out    = dq_out_reg;
	assign flash_dq_oe     = dq_oe_reg;
	assign flash_ce_n      = ce_n_reg;
	assign flash_we_n      = we_n_reg;
	assign flash_oe_n      = oe_n_reg;

	// ==========================================
	// checks
	sequence we_pulse_s;
		(!we_n_reg)[*4] ##1 we_n_reg;
	endsequence

	no_contention_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(dq_oe_reg && !oe_n_reg)) else $error("bus driven during read");
	strobe_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(!we_n_reg && !oe_n_reg)) else $error("write and read strobes both low");
	we_width_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(we_n_reg) |-> we_pulse_s) else $error("write pulse width wrong");
	addr_stable_a: assert property (@(posedge clk) disable iff (sys_rst)
		!we_n_reg && !$past(we_n_reg) |-> $stable(flash_addr)) else $error("address moved");
	susp_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && cmd.op == flash_host_pkg::OP_SUSPEND && !active_reg |=> cmd_refused)
		else $error("suspend sent without running erase");
	resume_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && cmd.op == flash_host_pkg::OP_RESUME && !susp_reg |=> cmd_refused
		##0 state_reg == ST_IDLE) else $error("resume sent while not suspended");
	susp_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(susp_reg) |-> $past(state_reg) == ST_WAIT && $past(cnt_reg) == SUSP_LAST)
		else $error("suspended flagged before halt time");
	byp_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
		take && cmd.op == flash_host_pkg::OP_BYP_PROG && !byp_reg |=> cmd_refused)
		else $error("bypass program outside bypass mode");
	wc_value_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(we_n_reg) && cmd_reg.op == flash_host_pkg::OP_BUF_LOAD && idx_reg == 3'h3
		|-> flash_dq_out == 16'(cmd_reg.data - 16'h0001)) else $error("word count wrong");

endmodule

// ===== design/flash_host_pkg.sv
// types and constants for the flash command host controller
package flash_host_pkg;

	// ==========================================
	// widths
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 14;

	// ==========================================
	// timing, ns per clock and printed figures
	localparam int CLK_NS        = 10;
	localparam int WE_PULSE_NS   = 35;
	localparam int RD_ACCESS_NS  = 90;
	localparam int HOLD_NS       = 30;
	localparam int SUSP_MAX_US   = 20;
	localparam int RESUME_GAP_US = 100;
	localparam int WE_CYC    = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC    = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC  = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUSP_CYC  = (SUSP_MAX_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int RGAP_CYC  = (RESUME_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;

	// ==========================================
	// addresses and command codes
	localparam logic [ADDR_W-1:0] A_ANY      = 22'h000000;
	localparam logic [ADDR_W-1:0] A_UNLOCK1  = 22'h000555;
	localparam logic [ADDR_W-1:0] A_UNLOCK2  = 22'h0002aa;
	localparam logic [ADDR_W-1:0] SECT_MASK  = 22'h3f8000;
	localparam logic [ADDR_W-1:0] OFF_ID1    = 22'h000001;
	localparam logic [ADDR_W-1:0] OFF_ID2    = 22'h00000e;
	localparam logic [ADDR_W-1:0] OFF_ID3    = 22'h00000f;
	localparam logic [ADDR_W-1:0] OFF_PROT   = 22'h000002;
	localparam logic [ADDR_W-1:0] OFF_LOCK   = 22'h000003;
	localparam logic [DATA_W-1:0] D_UNLOCK1  = 16'h00aa;
	localparam logic [DATA_W-1:0] D_UNLOCK2  = 16'h0055;
	localparam logic [DATA_W-1:0] D_AUTOSEL  = 16'h0090;
	localparam logic [DATA_W-1:0] D_ZERO     = 16'h0000;
	localparam logic [DATA_W-1:0] D_RESET    = 16'h00f0;
	localparam logic [DATA_W-1:0] D_SUSPEND  = 16'h00b0;
	localparam logic [DATA_W-1:0] D_RESUME   = 16'h0030;
	localparam logic [DATA_W-1:0] D_ERASE    = 16'h0080;
	localparam logic [DATA_W-1:0] D_SECT_ERS = 16'h0030;
	localparam logic [DATA_W-1:0] D_PROGRAM  = 16'h00a0;
	localparam logic [DATA_W-1:0] D_BYPASS   = 16'h0020;
	localparam logic [DATA_W-1:0] D_BUF_LOAD = 16'h0025;
	localparam logic [DATA_W-1:0] D_BUF_GO   = 16'h0029;
	localparam logic [DATA_W-1:0] D_ONE      = 16'h0001;

	// ==========================================
	// user operations
	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_SUSPEND, OP_RESUME, OP_SECT_ERASE, OP_PROGRAM,
		OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_EXIT, OP_BUF_LOAD, OP_BUF_WORD,
		OP_BUF_COMMIT, OP_BUF_ABORT, OP_DEV_ID, OP_PROT_VERIFY, OP_LOCK_IND
	} op_e;

	typedef enum logic [1:0] {AS_CONST, AS_USER, AS_SECT} asel_e;
	typedef enum logic [1:0] {DS_CONST, DS_USER, DS_WC} dsel_e;

	typedef struct packed {
		op_e               op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cmd_s;

	typedef struct packed {
		logic              rd;
		logic              last;
		asel_e             asel;
		logic [ADDR_W-1:0] aval;
		dsel_e             dsel;
		logic [DATA_W-1:0] dval;
	} step_s;

endpackage

// ===== design/flash_host_unused.sv
// (intentionally empty; all logic lives in flash_cmd_host)
`timescale 1ns/10ps
